/* inc/smps_pkg.sv */
package smps_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int NUM_SVC = 50;
  localparam int HDR_BYTES = 4;
  localparam int BAUD_2400 = 2400;
  localparam int BAUD_4800 = 4800;
  localparam int BAUD_9600 = 9600;
  localparam int BAUD_19200 = 19200;
  localparam int BAUD_38400 = 38400;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [7:0] NO_ADDR = 8'hff;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_CONFIG = 8'h08;
  localparam logic [7:0] A_POLL = 8'h0c;
  localparam logic [7:0] A_TXCNT = 8'h10;
  localparam logic [7:0] A_RXCNT = 8'h14;
  localparam logic [7:0] A_CNTLOC = 8'h18;
  localparam logic [7:0] A_SEL = 8'h1c;
  localparam logic [7:0] A_SCFG = 8'h20;
  localparam logic [7:0] A_STIME = 8'h24;
  localparam logic [7:0] A_SDATA = 8'h28;
  // config register fields
  localparam int CF_MADDR = 0;
  localparam int CF_BAUD = 8;
  localparam int CF_PAR = 11;
  localparam int CF_CS = 13;
  localparam int CF_MRST = 15;
  localparam int CF_STATS = 16;
  // service config fields
  localparam int SCFG_W = 19;
  localparam int SC_NODE = 0;
  localparam int SC_CRC = 8;
  localparam int SC_MODE = 9;
  localparam int SC_FBOFF = 11;
  localparam int SC_SNFRZ = 13;
  localparam int SC_RETRY = 14;
  localparam int SC_EN = 18;
  // service timing fields
  localparam int ST_TO = 0;
  localparam int ST_UPD = 16;
  // reset values
  localparam logic [7:0] RST_MADDR = 8'h01;
  localparam logic [2:0] RST_BAUD = 3'h4;
  localparam logic [15:0] RST_POLL_ACT = 16'h000a;
  localparam logic [15:0] RST_POLL_INACT = 16'h0064;
  localparam logic [3:0] RST_RETRIES = 4'h3;
  localparam logic [15:0] RST_TIMEOUT = 16'h0064;
  localparam logic [15:0] RST_UPDATE = 16'h0064;
  localparam logic [31:0] RST_CNTLOC = 32'h0002_0000;
  localparam logic [SCFG_W-1:0] RST_SCFG =
    SCFG_W'({RST_RETRIES, 5'h00, 1'b1, 8'h00});

  typedef enum logic [1:0] {CS_LOCK, CS_NOLOCK, CS_OFF} smps_cs_t;
  typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN} smps_par_t;
  typedef enum logic [1:0] {
    UPD_CYCLIC, UPD_CHANGE, UPD_SINGLE, UPD_TRIG
  } smps_upd_t;
  typedef enum logic [1:0] {FB_CLEAR, FB_FREEZE, FB_NOSCAN} smps_fboff_t;

  function automatic logic [15:0] baud_div(input logic [2:0] sel);
    case (sel)
      3'h0: baud_div = 16'(CLK_HZ / BAUD_2400);
      3'h1: baud_div = 16'(CLK_HZ / BAUD_4800);
      3'h2: baud_div = 16'(CLK_HZ / BAUD_9600);
      3'h3: baud_div = 16'(CLK_HZ / BAUD_19200);
      default: baud_div = 16'(CLK_HZ / BAUD_38400);
    endcase
  endfunction : baud_div

  function automatic logic par_bit(input logic [1:0] par,
                                   input logic [7:0] b);
    par_bit = (par == PAR_ODD) ? ~^b : ^b;
  endfunction : par_bit

  function automatic logic [15:0] chk_next(input logic crc,
                                           input logic [15:0] acc,
                                           input logic [7:0] b);
    logic [15:0] c;
    c = acc ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    chk_next = crc ? c : acc + {8'h00, b};
  endfunction : chk_next

  function automatic logic [7:0] chk_byte(input logic crc,
                                          input logic [15:0] acc,
                                          input logic high);
    if (crc) begin
      chk_byte = high ? acc[15:8] : acc[7:0];
    end else begin
      chk_byte = 8'h00 - acc[7:0];
    end
  endfunction : chk_byte
endpackage : smps_pkg

/* design/smps_top.sv */
`timescale 1ns/1ps
// Overview of operation
// - device alone starts exchanges with a query
// - startup lock waits for data valid bit
// - no startup lock starts traffic at once
// - disabled control word hides control and status
// - fatal error restarts or halts with indication
// - master only, half duplex line
// - statistics count each good transaction
// - bit rate selectable, 38400 after reset
// - eight data, one stop, selectable parity
// - master address 0 to 254, default 1
// - active poll interval default 10 ticks
// - inactive poll interval default 100 ticks
// - per node check choice, crc default
// - node address 0 to 254 in queries
// - at most fifty services
// - fieldbus offline clears, freezes or stops scanning
// - subnet offline clears or freezes reported data
// - update mode cyclic, change, single, trigger
// - retries default 3, then node disconnected
// - wait timeout before resending a service
// - update time spaces two runs of service
module smps_top #(
  parameter int TICK_CYCLES = smps_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fieldbus_online,
  input wire logic fatal_error,
  input wire logic ser_rxd,
  output logic ser_txd,
  output logic ser_tx_en,
  output logic err_ind
);
  typedef enum logic [2:0] {
    S_SCAN, S_LOAD, S_TX, S_RX, S_POST, S_HALT
  } smps_state_t;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  smps_state_t state;
  logic data_valid, mrst_en, stats_en, halted, post_ok, rx_act, rx_bad;
  logic [7:0] master_addr, dout, rx_data;
  logic [2:0] baud_sel, pos;
  smps_pkg::smps_par_t par_mode;
  smps_pkg::smps_cs_t cs_mode;
  logic [15:0] poll_act, poll_inact, baud_cnt, acc, to_cnt;
  logic [31:0] tx_cnt, rx_cnt, cnt_loc, next_prdata;
  logic [5:0] sel, cur, scan_idx;
  logic [10:0] shreg;
  logic [3:0] nbit, tries;
  logic [20:0] tick_cnt;
  logic tick, fb_off, sn_off, cs_off, run_ok, elig_now, wr, sel_ok;
  logic restart, crc, rx_stop;
  logic [15:0] div;
  logic [2:0] flen;
  logic [7:0] tx_val, rx_exp;

  logic [smps_pkg::SCFG_W-1:0] svc_cfg [smps_pkg::NUM_SVC];
  logic [31:0] svc_time [smps_pkg::NUM_SVC];
  logic [7:0] svc_tx [smps_pkg::NUM_SVC];
  logic [7:0] svc_trig [smps_pkg::NUM_SVC];
  logic [7:0] svc_seen [smps_pkg::NUM_SVC];
  logic [7:0] svc_sent [smps_pkg::NUM_SVC];
  logic [7:0] svc_rx [smps_pkg::NUM_SVC];
  logic [15:0] svc_wait [smps_pkg::NUM_SVC];
  logic svc_disc [smps_pkg::NUM_SVC];
  logic svc_done [smps_pkg::NUM_SVC];

  function automatic logic elig(input logic [5:0] i);
    logic [smps_pkg::SCFG_W-1:0] c;
    c = svc_cfg[i];
    elig = 1'b0;
    if (c[smps_pkg::SC_EN] && svc_wait[i] == 16'h0000 &&
        !(fb_off && c[smps_pkg::SC_FBOFF+:2] == smps_pkg::FB_NOSCAN)) begin
      if (svc_disc[i]) begin
        elig = 1'b1;
      end else begin
        case (c[smps_pkg::SC_MODE+:2])
          smps_pkg::UPD_CYCLIC: elig = 1'b1;
          smps_pkg::UPD_CHANGE: elig = svc_tx[i] != svc_sent[i];
          smps_pkg::UPD_SINGLE: elig = !svc_done[i];
          default: elig = svc_trig[i] != svc_seen[i];
        endcase
      end
    end
  endfunction : elig

  function automatic logic [7:0] data_out(input logic [5:0] i);
    data_out = svc_tx[i];
    if (fb_off) begin
      case (svc_cfg[i][smps_pkg::SC_FBOFF+:2])
        smps_pkg::FB_CLEAR: data_out = 8'h00;
        smps_pkg::FB_FREEZE: data_out = svc_sent[i];
        default: data_out = svc_tx[i];
      endcase
    end
  endfunction : data_out

  // 10 ms tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 21'h000000;
    end else if (tick) begin
      tick_cnt <= 21'h000000;
    end else begin
      tick_cnt <= tick_cnt + 21'h000001;
    end
  end
  assign tick = tick_cnt == 21'(TICK_CYCLES - 1);

  assign fb_off = !fieldbus_online;
  assign cs_off = cs_mode == smps_pkg::CS_OFF;
  assign wr = psel && penable && pwrite;
  assign sel_ok = sel < 6'(smps_pkg::NUM_SVC);
  assign run_ok = !halted &&
                  (cs_mode != smps_pkg::CS_LOCK || data_valid);
  // always_comb also follows the arrays read inside the function
  always_comb begin
    elig_now = elig(scan_idx);
  end
  assign restart = fatal_error && state != S_HALT && mrst_en;
  assign crc = svc_cfg[cur][smps_pkg::SC_CRC];
  assign flen = crc ? 3'h5 : 3'h4;
  assign div = smps_pkg::baud_div(baud_sel);
  assign rx_stop = nbit == ((par_mode == smps_pkg::PAR_NONE) ? 4'h9 : 4'ha);

  // global registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_valid <= 1'b0;
      master_addr <= smps_pkg::RST_MADDR;
      baud_sel <= smps_pkg::RST_BAUD;
      par_mode <= smps_pkg::PAR_NONE;
      cs_mode <= smps_pkg::CS_LOCK;
      mrst_en <= 1'b1;
      stats_en <= 1'b0;
      poll_act <= smps_pkg::RST_POLL_ACT;
      poll_inact <= smps_pkg::RST_POLL_INACT;
      cnt_loc <= smps_pkg::RST_CNTLOC;
      sel <= 6'h00;
    end else if (wr) begin
      case (paddr)
        smps_pkg::A_CTRL: if (!cs_off) data_valid <= pwdata[0];
        smps_pkg::A_CONFIG: begin
          if (pwdata[smps_pkg::CF_MADDR+:8] != smps_pkg::NO_ADDR) begin
            master_addr <= pwdata[smps_pkg::CF_MADDR+:8];
          end
          baud_sel <= pwdata[smps_pkg::CF_BAUD+:3];
          par_mode <= smps_pkg::smps_par_t'(pwdata[smps_pkg::CF_PAR+:2]);
          cs_mode <= smps_pkg::smps_cs_t'(pwdata[smps_pkg::CF_CS+:2]);
          mrst_en <= pwdata[smps_pkg::CF_MRST];
          stats_en <= pwdata[smps_pkg::CF_STATS];
        end
        smps_pkg::A_POLL: begin
          poll_act <= pwdata[15:0];
          poll_inact <= pwdata[31:16];
        end
        smps_pkg::A_CNTLOC: cnt_loc <= pwdata;
        smps_pkg::A_SEL: sel <= pwdata[5:0];
        default: ;
      endcase
    end
  end

  // service settings written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < smps_pkg::NUM_SVC; i++) begin
        svc_cfg[i] <= smps_pkg::RST_SCFG;
        svc_time[i] <= {smps_pkg::RST_UPDATE, smps_pkg::RST_TIMEOUT};
        svc_tx[i] <= 8'h00;
        svc_trig[i] <= 8'h00;
      end
    end else if (wr && sel_ok) begin
      case (paddr)
        smps_pkg::A_SCFG: begin
          svc_cfg[sel] <= pwdata[smps_pkg::SCFG_W-1:0];
          // node 255 is not a valid slave address
          if (pwdata[smps_pkg::SC_NODE+:8] == smps_pkg::NO_ADDR) begin
            svc_cfg[sel][smps_pkg::SC_NODE+:8] <= 8'hfe;
          end
        end
        smps_pkg::A_STIME: svc_time[sel] <= pwdata;
        smps_pkg::A_SDATA: begin
          svc_tx[sel] <= pwdata[7:0];
          svc_trig[sel] <= pwdata[15:8];
        end
        default: ;
      endcase
    end
  end

  // read data captured in the setup phase, so no wait states
  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      smps_pkg::A_CTRL: next_prdata = {31'h0, data_valid && !cs_off};
      smps_pkg::A_STATUS: if (!cs_off) next_prdata = {18'h0, cur, 4'h0,
          halted, sn_off, fb_off, state != S_SCAN && state != S_HALT};
      smps_pkg::A_CONFIG: next_prdata = {15'h0, stats_en, mrst_en,
          cs_mode, par_mode, baud_sel, master_addr};
      smps_pkg::A_POLL: next_prdata = {poll_inact, poll_act};
      smps_pkg::A_TXCNT: next_prdata = tx_cnt;
      smps_pkg::A_RXCNT: next_prdata = rx_cnt;
      smps_pkg::A_CNTLOC: next_prdata = cnt_loc;
      smps_pkg::A_SEL: next_prdata = {26'h0, sel};
      smps_pkg::A_SCFG: if (sel_ok) next_prdata = 32'(svc_cfg[sel]);
      smps_pkg::A_STIME: if (sel_ok) next_prdata = svc_time[sel];
      smps_pkg::A_SDATA: if (sel_ok) next_prdata = {8'h0, svc_rx[sel],
          svc_trig[sel], svc_tx[sel]};
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= next_prdata;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && (paddr > smps_pkg::A_SDATA ||
                   paddr[1:0] != 2'h0);

  cs_off_a: assert property ((psel && !penable && !pwrite &&
      paddr == smps_pkg::A_CTRL && cs_off) |=> prdata == 32'h0)
    else $error("control register visible while disabled");

  // query byte for the current position
  always_comb begin
    case (pos)
      3'h0: tx_val = svc_cfg[cur][smps_pkg::SC_NODE+:8];
      3'h1: tx_val = master_addr;
      3'h2: tx_val = {2'h0, cur};
      3'h3: tx_val = dout;
      default: tx_val = smps_pkg::chk_byte(crc, acc, pos == 3'h5);
    endcase
  end

  // expected answer byte
  always_comb begin
    case (pos)
      3'h0: rx_exp = master_addr;
      3'h1: rx_exp = svc_cfg[cur][smps_pkg::SC_NODE+:8];
      3'h2: rx_exp = {2'h0, cur};
      3'h3: rx_exp = shreg[7:0];
      default: rx_exp = smps_pkg::chk_byte(crc, acc, pos == 3'h5);
    endcase
  end

  // link engine: one bit timer shared, the line is never both ways
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_SCAN;
      halted <= 1'b0;
      scan_idx <= 6'h00;
      cur <= 6'h00;
      pos <= 3'h0;
      shreg <= 11'h7ff;
      nbit <= 4'h0;
      baud_cnt <= 16'h0000;
      acc <= 16'h0000;
      tries <= 4'h0;
      to_cnt <= 16'h0000;
      rx_act <= 1'b0;
      rx_bad <= 1'b0;
      post_ok <= 1'b0;
      dout <= 8'h00;
      rx_data <= 8'h00;
    end else if (fatal_error && state != S_HALT) begin
      state <= mrst_en ? S_SCAN : S_HALT;
      halted <= !mrst_en;
      rx_act <= 1'b0;
    end else begin
      case (state)
        S_SCAN: begin
          scan_idx <= (scan_idx == 6'(smps_pkg::NUM_SVC - 1)) ? 6'h00
                      : scan_idx + 6'h01;
          if (run_ok && elig_now) begin
            cur <= scan_idx;
            dout <= data_out(scan_idx);
            pos <= 3'h0;
            acc <= 16'h0000;
            tries <= 4'h0;
            state <= S_LOAD;
          end
        end
        S_LOAD: begin
          shreg <= {1'b1, smps_pkg::par_bit(par_mode, tx_val), tx_val,
                    1'b0};
          nbit <= (par_mode == smps_pkg::PAR_NONE) ? 4'ha : 4'hb;
          if (par_mode == smps_pkg::PAR_NONE) shreg[9] <= 1'b1;
          if (pos < 3'(smps_pkg::HDR_BYTES)) begin
            acc <= smps_pkg::chk_next(crc, acc, tx_val);
          end
          baud_cnt <= div - 16'h0001;
          state <= S_TX;
        end
        S_TX: begin
          if (baud_cnt != 16'h0000) begin
            baud_cnt <= baud_cnt - 16'h0001;
          end else begin
            baud_cnt <= div - 16'h0001;
            shreg <= {1'b1, shreg[10:1]};
            nbit <= nbit - 4'h1;
            if (nbit == 4'h1) begin
              pos <= (pos == flen) ? 3'h0 : pos + 3'h1;
              acc <= (pos == flen) ? 16'h0000 : acc;
              state <= (pos == flen) ? S_RX : S_LOAD;
              to_cnt <= 16'h0000;
              rx_act <= 1'b0;
              rx_bad <= 1'b0;
            end
          end
        end
        S_RX: begin
          if (tick) to_cnt <= to_cnt + 16'h0001;
          if (to_cnt >= svc_time[cur][smps_pkg::ST_TO+:16]) begin
            if (tries < svc_cfg[cur][smps_pkg::SC_RETRY+:4]) begin
              tries <= tries + 4'h1;
              pos <= 3'h0;
              acc <= 16'h0000;
              state <= S_LOAD;
            end else begin
              post_ok <= 1'b0;
              state <= S_POST;
            end
          end else if (!rx_act) begin
            // a line idle low starts a new byte again after every stop bit
            if (!ser_rxd) begin
              rx_act <= 1'b1;
              nbit <= 4'h0;
              baud_cnt <= div >> 1;
            end
          end else if (baud_cnt != 16'h0000) begin
            baud_cnt <= baud_cnt - 16'h0001;
          end else begin
            baud_cnt <= div - 16'h0001;
            nbit <= nbit + 4'h1;
            if (nbit == 4'h0) begin
              if (ser_rxd) rx_act <= 1'b0;
            end else if (nbit <= 4'h8) begin
              shreg[7:0] <= {ser_rxd, shreg[7:1]};
            end else if (!rx_stop) begin
              if (ser_rxd != smps_pkg::par_bit(par_mode, shreg[7:0])) begin
                rx_bad <= 1'b1;
              end
            end else begin
              rx_act <= 1'b0;
              pos <= pos + 3'h1;
              if (pos < 3'(smps_pkg::HDR_BYTES)) begin
                acc <= smps_pkg::chk_next(crc, acc, shreg[7:0]);
              end
              if (pos == 3'h3) rx_data <= shreg[7:0];
              if (!ser_rxd || shreg[7:0] != rx_exp) begin
                rx_bad <= 1'b1;
              end else if (pos == flen && !rx_bad) begin
                post_ok <= 1'b1;
                state <= S_POST;
              end
            end
          end
        end
        S_POST: state <= S_SCAN;
        S_HALT: state <= S_HALT;
        default: state <= S_SCAN;
      endcase
    end
  end

  assign ser_tx_en = state == S_TX;
  assign ser_txd = (state == S_TX) ? shreg[0] : 1'b1;
  assign err_ind = halted;

  duplex_a: assert property (state == S_RX |->
      (!ser_tx_en && ser_txd) throughout (state == S_RX)[*1])
    else $error("line driven while listening");
  lock_hold_a: assert property ((state == S_SCAN && !data_valid &&
      cs_mode == smps_pkg::CS_LOCK && !fatal_error) |=> state != S_LOAD)
    else $error("traffic started before data valid");
  nolock_go_a: assert property ((state == S_SCAN && elig_now &&
      cs_mode == smps_pkg::CS_NOLOCK && !halted && !fatal_error)
      |=> state == S_LOAD ##1 state == S_TX)
    else $error("traffic did not start without lock");
  halt_err_a: assert property ((fatal_error && !mrst_en) |=>
      (halted && err_ind && state == S_HALT)[*2])
    else $error("fatal error did not halt");
  restart_a: assert property ((fatal_error && mrst_en && !halted)
      |=> state == S_SCAN && !err_ind)
    else $error("fatal error did not restart silently");
  retry_a: assert property ((state == S_POST && !post_ok) |->
      tries == svc_cfg[cur][smps_pkg::SC_RETRY+:4])
    else $error("node dropped before retries ran out");
  master_addr_a: assert property (master_addr != smps_pkg::NO_ADDR)
    else $error("master address out of range");

  // scheduler state per service
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < smps_pkg::NUM_SVC; i++) begin
        svc_wait[i] <= 16'h0000;
        svc_disc[i] <= 1'b0;
        svc_done[i] <= 1'b0;
        svc_sent[i] <= 8'h00;
        svc_seen[i] <= 8'h00;
        svc_rx[i] <= 8'h00;
      end
    end else if (restart) begin
      for (int i = 0; i < smps_pkg::NUM_SVC; i++) begin
        svc_wait[i] <= 16'h0000;
        svc_done[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < smps_pkg::NUM_SVC; i++) begin
        if (tick && svc_wait[i] != 16'h0000) begin
          svc_wait[i] <= svc_wait[i] - 16'h0001;
        end
      end
      if (state == S_POST && post_ok) begin
        svc_disc[cur] <= 1'b0;
        svc_done[cur] <= 1'b1;
        svc_sent[cur] <= dout;
        svc_seen[cur] <= svc_trig[cur];
        svc_rx[cur] <= rx_data;
        // later of update time and active poll interval
        svc_wait[cur] <= (svc_time[cur][smps_pkg::ST_UPD+:16] > poll_act)
                         ? svc_time[cur][smps_pkg::ST_UPD+:16]
                         : poll_act;
      end else if (state == S_POST) begin
        svc_disc[cur] <= 1'b1;
        svc_wait[cur] <= poll_inact;
        if (!svc_cfg[cur][smps_pkg::SC_SNFRZ]) svc_rx[cur] <= 8'h00;
      end
    end
  end

  always_comb begin
    sn_off = 1'b0;
    for (int i = 0; i < smps_pkg::NUM_SVC; i++) begin
      sn_off = sn_off | svc_disc[i];
    end
  end

  gap_a: assert property ((state == S_POST && post_ok && !restart)
      |=> svc_wait[cur] >= svc_time[cur][smps_pkg::ST_UPD+:16])
    else $error("service rescheduled before update time");

  // statistics; counters only count, software reads them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt <= 32'h0000_0000;
      rx_cnt <= 32'h0000_0000;
    end else if (state == S_POST && post_ok && stats_en) begin
      tx_cnt <= tx_cnt + 32'h0000_0001;
      rx_cnt <= rx_cnt + 32'h0000_0001;
    end
  end

  stats_a: assert property ((state == S_POST && post_ok && stats_en)
      |=> tx_cnt == $past(tx_cnt) + 32'h1 && rx_cnt == $past(rx_cnt) + 32'h1)
    else $error("statistics not counted");

  good_c: cover property (state == S_RX ##1 state == S_POST && post_ok);
  resend_c: cover property (state == S_RX ##1 state == S_LOAD);
  drop_c: cover property (state == S_POST && !post_ok);
  halt_c: cover property (state == S_HALT);
endmodule : smps_top

/* verification/smps_slave_model.sv */
`timescale 1ns/1ps
module smps_slave_model (
  input wire logic pclk,
  input wire logic ser_txd,
  input wire logic ser_tx_en,
  output logic ser_rxd
);
  // runs are shorter than one whole query, so no answer is ever owed
  assign ser_rxd = 1'b1; // idle high, never answers unasked
endmodule : smps_slave_model

/* verification/testbench.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, se, ser_rxd, ser_txd, ser_tx_en, err_ind;
  logic fatal_error = 0;
  logic fieldbus_online = 1;
  logic [7:0] m;
  int errors = 0;
  int checked = 0;
  int n;
  localparam int BT = smps_pkg::CLK_HZ / smps_pkg::BAUD_38400;
  always #4 pclk = ~pclk;
  smps_top #(.TICK_CYCLES(50)) u_smps_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fieldbus_online(fieldbus_online), .fatal_error(fatal_error),
    .ser_rxd(ser_rxd), .ser_txd(ser_txd), .ser_tx_en(ser_tx_en),
    .err_ind(err_ind));
  smps_slave_model u_smps_slave_model (.pclk(pclk), .ser_txd(ser_txd),
    .ser_tx_en(ser_tx_en), .ser_rxd(ser_rxd));
  task automatic report_and_stop;
    if (errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      errors++;
      report_and_stop;
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_tx;
    n = 0;
    while (ser_tx_en !== 1'b1 && n < 400) begin
      @(negedge pclk);
      n++;
    end
    `CHK("tx_en", 1'b1, ser_tx_en)
    `CHK("start_bit", 1'b0, ser_txd)
    if (n >= 400) begin
      report_and_stop;
    end
  endtask : wait_tx
  function automatic logic exp_bit(input logic [7:0] b, input int i);
    if (i >= 1 && i <= 8) begin
      exp_bit = b[i-1];
    end else begin
      exp_bit = i != 0;
    end
  endfunction : exp_bit
  task automatic count_tx;
    n = 0;
    repeat (200) begin
      @(negedge pclk);
      n += int'(ser_tx_en === 1'b1);
    end
  endtask : count_tx
  // called at the first cycle of a start bit; samples mid bit
  task automatic check_byte(input logic [7:0] b);
    repeat (BT / 2) @(negedge pclk);
    for (int i = 1; i < 10; i++) begin
      repeat (BT) @(negedge pclk);
      `CHK("tx_bit", exp_bit(b, i), ser_txd)
      `CHK("tx_hold", 1'b1, ser_tx_en)
    end
  endtask : check_byte
  task automatic fatal(input logic [31:0] cfg);
    apb(1'b1, smps_pkg::A_CONFIG, cfg);
    @(posedge pclk);
    fatal_error <= 1'b1;
    @(posedge pclk);
    fatal_error <= 1'b0;
    repeat (5) @(negedge pclk);
  endtask : fatal
  initial begin
    repeat (90000) @(posedge pclk);
    errors++;
    report_and_stop;
  end
  initial begin
    void'($urandom(76799));
    m = 8'($urandom_range(254));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, smps_pkg::A_CONFIG, 0);
    `CHK("config", 32'h0000_8401, rd)
    apb(1'b0, smps_pkg::A_POLL, 0);
    `CHK("poll", 32'h0064_000a, rd)
    apb(1'b0, smps_pkg::A_SCFG, 0);
    `CHK("scfg", 32'h0000_c100, rd)
    apb(1'b0, smps_pkg::A_STIME, 0);
    `CHK("stime", 32'h0064_0064, rd)
    apb(1'b0, 8'h2c, 0);
    `CHK("unmapped", 1'b1, se)
    `CHK("ready", 1'b1, pready)
    apb(1'b1, smps_pkg::A_CONFIG, 32'h0000_8400 | m);
    apb(1'b1, smps_pkg::A_CONFIG, 32'h0000_84ff);
    apb(1'b0, smps_pkg::A_CONFIG, 0);
    `CHK("maddr", 32'h0000_8400 | m, rd)
    apb(1'b1, smps_pkg::A_SEL, 32'd50);
    apb(1'b0, smps_pkg::A_SCFG, 0);
    `CHK("sel50", 32'h0, rd)
    apb(1'b1, smps_pkg::A_SEL, 32'd0);
    apb(1'b1, smps_pkg::A_SCFG, 32'h0004_c100 | m);
    apb(1'b0, smps_pkg::A_SCFG, 0);
    `CHK("node", 32'h0004_c100 | m, rd)
    count_tx;
    `CHK("locked", 0, n)
    apb(1'b1, smps_pkg::A_CTRL, 32'h1);
    wait_tx;
    fatal(32'h0000_8400 | m);
    `CHK("restart", 1'b0, err_ind)
    fatal(32'h0000_0400 | m);
    `CHK("halt", 1'b1, err_ind)
    `CHK("halt_tx", 1'b0, ser_tx_en)
    apb(1'b1, smps_pkg::A_CONFIG, 32'h0000_4400 | m);
    apb(1'b0, smps_pkg::A_STATUS, 0);
    `CHK("cs_off", 32'h0, rd)
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, smps_pkg::A_CONFIG, 32'h0000_a401);
    fieldbus_online <= 1'b0;
    apb(1'b1, smps_pkg::A_SCFG, 32'h0004_d100 | m);
    count_tx;
    `CHK("noscan", 0, n)
    apb(1'b0, smps_pkg::A_STATUS, 0);
    `CHK("fb_off", 32'h0000_0002, rd)
    fieldbus_online <= 1'b1;
    wait_tx;
    check_byte(m);
    report_and_stop;
  end
endmodule : testbench
